// file: design/sarcc_defs.svh
// Purpose: offsets, field positions, reset values and counts of the sar converter control
// Assumes: one tick of sys_clk equals one oscillator period
// Notes:   register offsets, field positions and sequencing counts live here; divider limits and pin masks sit in their modules
//
// Overview of operation
// - an 8-bit result is built from the held sample by successive approximation
// - conversion clock select 00/01/10/11 picks 2, 8, 32 oscillator periods or rc clock
// - channel select field at bits 4..3 routes input 0..3 to the sample-and-hold
// - on completion load result, clear go/done bit 2, set the complete flag
// - power-on bit zero shuts the converter off; one keeps it operating
// - one conversion takes nine and a half bit periods of the chosen clock
// - after each conversion the capacitor stays disconnected for two bit periods
// - the holding capacitor is never discharged between conversions
// - operation during sleep is possible only with the rc conversion clock
// - bits 7..2 of the pin setup register read zero and ignore writes
// - clearing go/done mid-conversion aborts, keeps result, reacquires after two bit periods
// - rc clock waits one instruction cycle before converting; else sleep aborts and powers down
// - with the interrupt enabled a conversion finishing in sleep wakes the device
`ifndef SARCC_DEFS_SVH
`define SARCC_DEFS_SVH

// register offsets
`define SARCC_OFS_CTRL      8'h08
`define SARCC_OFS_CTRL_ALT  8'h1f
`define SARCC_OFS_PIN       8'h88
`define SARCC_OFS_PIN_ALT   8'h9f
`define SARCC_OFS_RESULT    8'h09
`define SARCC_OFS_IRQ       8'h0b

// conversion_control fields
`define SARCC_CLK_HI   7
`define SARCC_CLK_LO   6
`define SARCC_CHAN_HI  4
`define SARCC_CHAN_LO  3
`define SARCC_GO_BIT   2
`define SARCC_FLAG_BIT 1
`define SARCC_PWR_BIT  0
// irq control fields
`define SARCC_GIE_BIT  7
`define SARCC_CONVERSION_IRQ_ENABLE_BIT 6

// clock select codes
`define SARCC_CLK_RC   2'h3
// pin configuration codes
`define SARCC_PCFG_ALL_ANALOG 2'h0
`define SARCC_PCFG_EXT_REF    2'h1

// reset value of every control field
`define SARCC_RST_BYTE 8'h00

// timing in half bit periods
`define SARCC_SETUP_HALF 5'h03
`define SARCC_LAST_STEP  5'h12
`define SARCC_CONV_HALF  5'h13
`define SARCC_POST_HALF  5'h04
// one instruction cycle in oscillator periods
`define SARCC_INSTR_CYC  3'h4

`endif

// file: design/sarcc_pkg.sv
// Purpose: types of the sar converter control
// Assumes: nothing beyond the defs header
// Notes:   each module keeps its whole state in one struct from here
package sarcc_pkg;

  typedef enum logic [1:0] {
    SARCC_ST_ACQ,
    SARCC_ST_DELAY,
    SARCC_ST_CONV,
    SARCC_ST_POST
  } sarcc_state_t;

  typedef struct packed {
    logic [3:0] cnt;
  } sarcc_tad_s_t;

  typedef struct packed {
    logic [7:0] trial;
    logic [2:0] idx;
    logic       busy;
  } sarcc_sar_s_t;

  typedef struct packed {
    logic [1:0]   clk_sel;
    logic [1:0]   chan;
    logic         go;
    logic         flag;
    logic         pwr;
    logic [1:0]   pcfg;
    logic [7:0]   result;
    logic         conversion_irq_enable;
    logic         global_irq_enable;
    sarcc_state_t st;
    logic [4:0]   hcnt;
    logic [2:0]   dcnt;
    logic [7:0]   rdata;
    logic         wake;
  } sarcc_top_s_t;

endpackage

// file: design/sarcc_tad_gen.sv
// Purpose: half bit-period tick from the selected conversion clock
// Assumes: rc_half_tick is a one-cycle pulse at twice the rc bit rate
// Notes:   divider restarts whenever run is low so the first tick is a full half period
`timescale 1ns/1ps
`default_nettype none
`include "sarcc_defs.svh"

module sarcc_tad_gen (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       run,
  input  wire logic [1:0] clk_sel,
  input  wire logic       rc_half_tick,
  output logic            half_tick
);
  import sarcc_pkg::*;

  sarcc_tad_s_t r;
  sarcc_tad_s_t next_r;
  logic [3:0]   lim;

  // half of 2, 8, 32 oscillator periods, minus one
  function automatic logic [3:0] half_limit(input logic [1:0] sel);
    case (sel)
      2'h0:    half_limit = 4'h0;
      2'h1:    half_limit = 4'h3;
      default: half_limit = 4'hf;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // divider
  always_comb begin
    next_r = r;
    lim    = half_limit(clk_sel);
    if (!run || r.cnt == lim) begin
      next_r.cnt = 4'h0;
    end else begin
      next_r.cnt = r.cnt + 4'h1;
    end
    if (clk_sel == `SARCC_CLK_RC) begin
      half_tick = run & rc_half_tick;
    end else begin
      half_tick = run & (r.cnt == lim);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

endmodule // sarcc_tad_gen
`default_nettype wire

// file: design/sarcc_sar.sv
// Purpose: successive approximation register, msb first
// Assumes: cmp_high is high when the held sample is above the dac level
// Notes:   trial code drives the dac; after eight steps it is the result
`timescale 1ns/1ps
`default_nettype none

module sarcc_sar (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       start,
  input  wire logic       step,
  input  wire logic       cmp_high,
  output logic [7:0]      code
);
  import sarcc_pkg::*;

  sarcc_sar_s_t r;
  sarcc_sar_s_t next_r;

  ////////////////////////////////////////////////////////////////////////
  // bit decisions
  always_comb begin
    next_r = r;
    if (start) begin
      next_r.trial = 8'h80;
      next_r.idx   = 3'h7;
      next_r.busy  = 1'b1;
    end else if (step && r.busy) begin
      // keep the bit only when the sample is above the trial level
      if (!cmp_high) begin
        next_r.trial[r.idx] = 1'b0;
      end
      if (r.idx == 3'h0) begin
        next_r.busy = 1'b0;
      end else begin
        next_r.trial[r.idx - 3'h1] = 1'b1;
        next_r.idx = r.idx - 3'h1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign code = r.trial;

endmodule // sarcc_sar
`default_nettype wire

// file: design/sarcc_top.sv
// Purpose: control of an 8-bit four-input sar converter with register port
// Assumes: plain register port, read data one cycle after the read strobe
// Notes:   analog front end sits outside; this block steers it and collects bits
`timescale 1ns/1ps
`default_nettype none
`include "sarcc_defs.svh"

module sarcc_top (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_we,
  input  wire logic       reg_re,
  output logic [7:0]      reg_rdata,
  input  wire logic       cmp_high,
  input  wire logic       rc_half_tick,
  input  wire logic       sleep_mode,
  output logic [7:0]      dac_code,
  output logic            sample_connect,
  output logic [1:0]      channel_sel,
  output logic [3:0]      analog_pin_mask,
  output logic            vref_external,
  output logic            converter_active,
  output logic            irq,
  output logic            wake_request
);
  import sarcc_pkg::*;

  sarcc_top_s_t r;
  sarcc_top_s_t next_r;

  logic       half_tick;
  logic       run;
  logic       sar_start;
  logic       sar_step;
  logic [7:0] sar_code;
  logic [4:0] hnext;
  logic       wr_ctrl;
  logic       wr_pin;
  logic       wr_res;
  logic       wr_irq;
  logic       rc_sel;
  logic       sleep_kill;
  logic       sw_abort;
  logic       finish;

  // the control register answers at both of its addresses
  function automatic logic is_ctrl(input logic [7:0] a);
    is_ctrl = (a == `SARCC_OFS_CTRL) || (a == `SARCC_OFS_CTRL_ALT);
  endfunction

  function automatic logic is_pin(input logic [7:0] a);
    is_pin = (a == `SARCC_OFS_PIN) || (a == `SARCC_OFS_PIN_ALT);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // helpers
  sarcc_tad_gen u_tad (
    .sys_clk      (sys_clk),
    .sys_rst      (sys_rst),
    .run          (run),
    .clk_sel      (r.clk_sel),
    .rc_half_tick (rc_half_tick),
    .half_tick    (half_tick)
  );

  sarcc_sar u_sar (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .start    (sar_start),
    .step     (sar_step),
    .cmp_high (cmp_high),
    .code     (sar_code)
  );

  ////////////////////////////////////////////////////////////////////////
  // decode and sequencing terms
  always_comb begin
    wr_ctrl = reg_we && is_ctrl(reg_addr);
    wr_pin  = reg_we && is_pin(reg_addr);
    wr_res  = reg_we && (reg_addr == `SARCC_OFS_RESULT);
    wr_irq  = reg_we && (reg_addr == `SARCC_OFS_IRQ);
    rc_sel  = (r.clk_sel == `SARCC_CLK_RC);
    // sleep stops any clock but rc; the power bit itself stays set
    sleep_kill = sleep_mode && !rc_sel;
    // a software clear of go, or power removal, ends the conversion
    sw_abort = (wr_ctrl && !reg_wdata[`SARCC_GO_BIT]) || !r.pwr;
    // an abort restarts the divider, so on the 2, 8, 32 period clocks the wait after it is two full bit periods; rc ticks are only gated
    run      = ((r.st == SARCC_ST_CONV) && !sw_abort) || (r.st == SARCC_ST_POST);
    hnext    = r.hcnt + 5'h01;
    // eight decisions spread two half periods apart after the setup
    sar_step = (r.st == SARCC_ST_CONV) && half_tick && !hnext[0]
               && (hnext > `SARCC_SETUP_HALF) && (hnext <= `SARCC_LAST_STEP);
    finish   = (r.st == SARCC_ST_CONV) && half_tick
               && (hnext == `SARCC_CONV_HALF);
    sar_start = 1'b0;
    if ((r.st == SARCC_ST_ACQ) && r.go && r.pwr && !sleep_kill && !rc_sel) begin
      sar_start = 1'b1;
    end
    if ((r.st == SARCC_ST_DELAY) && (r.dcnt == `SARCC_INSTR_CYC - 3'h1)
        && !sw_abort && !sleep_kill) begin
      sar_start = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register file and conversion state machine
  always_comb begin
    next_r       = r;
    next_r.rdata = 8'h00;
    next_r.wake  = 1'b0;

    // software writes
    if (wr_ctrl) begin
      next_r.clk_sel = reg_wdata[`SARCC_CLK_HI:`SARCC_CLK_LO];
      next_r.chan    = reg_wdata[`SARCC_CHAN_HI:`SARCC_CHAN_LO];
      next_r.flag    = reg_wdata[`SARCC_FLAG_BIT];
      next_r.pwr     = reg_wdata[`SARCC_PWR_BIT];
      // go only latches while the converter is powered
      next_r.go = reg_wdata[`SARCC_GO_BIT] && reg_wdata[`SARCC_PWR_BIT];
    end
    if (wr_pin) begin
      next_r.pcfg = reg_wdata[1:0];
    end
    if (wr_res) begin
      next_r.result = reg_wdata;
    end
    if (wr_irq) begin
      next_r.global_irq_enable  = reg_wdata[`SARCC_GIE_BIT];
      next_r.conversion_irq_enable = reg_wdata[`SARCC_CONVERSION_IRQ_ENABLE_BIT];
    end
    if (!next_r.pwr) begin
      next_r.go = 1'b0;
    end

    // sequencing
    case (r.st)
      SARCC_ST_ACQ: begin
        next_r.hcnt = 5'h00;
        next_r.dcnt = 3'h0;
        if (r.go && r.pwr && !sleep_kill) begin
          // rc clock waits one instruction cycle so sleep can be entered
          next_r.st = rc_sel ? SARCC_ST_DELAY : SARCC_ST_CONV;
        end else if (r.go && sleep_kill) begin
          next_r.go = 1'b0;
        end
      end
      SARCC_ST_DELAY: begin
        next_r.dcnt = r.dcnt + 3'h1;
        if (sw_abort || sleep_kill) begin
          next_r.st = SARCC_ST_ACQ;
          next_r.go = 1'b0;
        end else if (r.dcnt == `SARCC_INSTR_CYC - 3'h1) begin
          next_r.st = SARCC_ST_CONV;
        end
      end
      SARCC_ST_CONV: begin
        if (sleep_kill) begin
          // converter shuts down; the partial code is dropped
          next_r.st   = SARCC_ST_ACQ;
          next_r.go   = 1'b0;
          next_r.hcnt = 5'h00;
        end else if (sw_abort) begin
          // result keeps its old value; a fresh acquisition follows the wait
          next_r.st   = SARCC_ST_POST;
          next_r.go   = 1'b0;
          next_r.hcnt = 5'h00;
        end else if (finish) begin
          next_r.result = sar_code;
          next_r.go     = 1'b0;
          next_r.flag   = 1'b1;
          next_r.st     = SARCC_ST_POST;
          next_r.hcnt   = 5'h00;
          next_r.wake   = sleep_mode && r.conversion_irq_enable;
        end else if (half_tick) begin
          next_r.hcnt = hnext;
        end
      end
      SARCC_ST_POST: begin
        // capacitor stays off the input for two bit periods
        if (half_tick) begin
          next_r.hcnt = hnext;
          if (hnext == `SARCC_POST_HALF) begin
            next_r.st   = SARCC_ST_ACQ;
            next_r.hcnt = 5'h00;
          end
        end
      end
      default: begin
        next_r.st = SARCC_ST_ACQ;
      end
    endcase

    // read data stands only in the cycle after the strobe
    if (reg_re) begin
      if (is_ctrl(reg_addr)) begin
        next_r.rdata = {r.clk_sel, 1'b0, r.chan, r.go, r.flag, r.pwr};
      end else if (is_pin(reg_addr)) begin
        next_r.rdata = {6'h00, r.pcfg};
      end else if (reg_addr == `SARCC_OFS_RESULT) begin
        next_r.rdata = r.result;
      end else if (reg_addr == `SARCC_OFS_IRQ) begin
        next_r.rdata = {r.global_irq_enable, r.conversion_irq_enable, 6'h00};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      r       <= '0;
      r.st    <= SARCC_ST_ACQ;
      r.rdata <= `SARCC_RST_BYTE;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // analog side controls
  always_comb begin
    reg_rdata     = r.rdata;
    dac_code      = sar_code;
    channel_sel   = r.chan;
    wake_request  = r.wake;
    irq           = r.flag && r.conversion_irq_enable && r.global_irq_enable;
    converter_active = r.pwr && !sleep_kill;
    // capacitor tracks the input in acquisition and the rc delay while active; never discharged
    sample_connect = converter_active
                     && ((r.st == SARCC_ST_ACQ) || (r.st == SARCC_ST_DELAY));
    case (r.pcfg)
      `SARCC_PCFG_ALL_ANALOG: begin
        analog_pin_mask = 4'hf;
        vref_external   = 1'b0;
      end
      `SARCC_PCFG_EXT_REF: begin
        analog_pin_mask = 4'h7;
        vref_external   = 1'b1;
      end
      default: begin
        analog_pin_mask = 4'h0;
        vref_external   = 1'b0;
      end
    endcase
  end

endmodule // sarcc_top
`default_nettype wire

// file: verif/sarcc_props.sv
// Purpose: port assertions for the sar converter control
// Assumes: one clock, reset synchronous and active high
// Notes:   the timing check covers select code 00 only
`timescale 1ns/1ps
`default_nettype none

module sarcc_props (
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_we,
  input wire logic       reg_re,
  input wire logic [7:0] reg_rdata,
  input wire logic       cmp_high,
  input wire logic       rc_half_tick,
  input wire logic       sleep_mode,
  input wire logic [7:0] dac_code,
  input wire logic       sample_connect,
  input wire logic [1:0] channel_sel,
  input wire logic [3:0] analog_pin_mask,
  input wire logic       vref_external,
  input wire logic       converter_active,
  input wire logic       irq,
  input wire logic       wake_request
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////
  // writes to either alias of a register
  sequence ctrl_wr;
    reg_we && (reg_addr == 8'h08 || reg_addr == 8'h1f);
  endsequence
  sequence pin_wr;
    reg_we && (reg_addr == 8'h88 || reg_addr == 8'h9f);
  endsequence
  // start on the fastest clock from an idle powered converter
  sequence fast_start;
    ctrl_wr ##0 (reg_wdata[7:6] == 2'h0 && reg_wdata[2] && reg_wdata[0] && sample_connect && converter_active);
  endsequence
  // cut off while converting, still cut off in the post wait, then acquiring
  sequence conv_then_gap;
    (!sample_connect && dac_code == 8'h80) ##22 !sample_connect ##1 sample_connect;
  endsequence

  ////////////////////////////////////////
  // each check but chk_pin_kind ties an output to the write or event behind it; chk_pin_kind ties the pin mask to vref_external
  chk_conv_timing: assert property (fast_start |=> ##1 conv_then_gap)
    else $error("conversion or post wait has the wrong length");
  chk_read_idle: assert property (!$past(reg_re) |-> reg_rdata == 8'h00)
    else $error("read data outside the read cycle");
  chk_pin_unused: assert property (reg_re && reg_addr inside {8'h88, 8'h9f} |=> reg_rdata[7:2] == 6'h00)
    else $error("unused pin setup bits read nonzero");
  chk_chan_route: assert property (ctrl_wr |=> channel_sel == $past(reg_wdata[4:3]))
    else $error("channel select does not follow the write");
  chk_pin_ref: assert property (pin_wr ##0 reg_wdata[1:0] == 2'h1 |=> vref_external && analog_pin_mask == 4'h7)
    else $error("external reference setup wrong");
  chk_pin_kind: assert property (vref_external ? analog_pin_mask == 4'h7 : analog_pin_mask inside {4'hf, 4'h0})
    else $error("illegal pin mask");
  chk_power_off: assert property (ctrl_wr ##0 !reg_wdata[0] |=> !converter_active)
    else $error("converter active with power bit clear");
  chk_irq_holds: assert property (irq && !(reg_we && reg_addr inside {8'h08, 8'h1f, 8'h0b}) |=> irq)
    else $error("interrupt dropped without a software write");
  chk_wake_pulse: assert property (wake_request |-> $past(sleep_mode) ##1 !wake_request)
    else $error("wake pulse outside sleep or too long");
endmodule // sarcc_props

bind sarcc_top sarcc_props chk_u (
  .sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata, .cmp_high, .rc_half_tick,
  .sleep_mode, .dac_code, .sample_connect, .channel_sel, .analog_pin_mask, .vref_external,
  .converter_active, .irq, .wake_request
);
`default_nettype wire

// file: verif/sarcc_top_tb.sv
// Purpose: self-checking bench for the sar converter control
// Assumes: one sys_clk period is one oscillator period
// Notes:   the sample sits half a step above vin, so a clean conversion returns vin
`timescale 1ns/1ps
`default_nettype none

module sarcc_top_tb;
  logic       sys_clk = 1'b0, sys_rst = 1'b1, reg_we = 1'b0, reg_re = 1'b0;
  logic       cmp_high = 1'b0, rc_half_tick = 1'b0, sleep_mode = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, dac_code;
  logic [1:0] channel_sel, rc_cnt = 2'h0;
  logic [3:0] analog_pin_mask;
  logic       sample_connect, vref_external, converter_active, irq, wake_request;
  int         fails = 0, checked = 0, cyc = 0, wakes = 0, vin = 0, old, w0;
  int         res_q[$];

  sarcc_top dut_u (
    .sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata, .cmp_high, .rc_half_tick,
    .sleep_mode, .dac_code, .sample_connect, .channel_sel, .analog_pin_mask, .vref_external,
    .converter_active, .irq, .wake_request
  );

  always #12.5 sys_clk = ~sys_clk;

  ////////////////////////////////////////
  // analog side and rc ticks; comparator lags a cycle, still ahead of each decision
  always @(posedge sys_clk) begin
    cmp_high     <= (vin[7:0] >= dac_code);
    rc_cnt       <= (rc_cnt == 2'h2) ? 2'h0 : rc_cnt + 2'h1;
    rc_half_tick <= (rc_cnt == 2'h2);
    wakes        <= wakes + int'(wake_request === 1'b1);
    cyc          <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (fails == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // bus cycles; a write leaves one idle cycle so strobes never toggle twice in a step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_we    <= 1'b1;
    @(posedge sys_clk);
    reg_we <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_re   <= 1'b1;
    @(posedge sys_clk);
    reg_re <= 1'b0;
    #1;
    check({8'h00, reg_rdata}, {8'h00, exp});
    @(posedge sys_clk);
  endtask

  // control byte with the power bit on
  function automatic logic [7:0] cb(input logic [1:0] s, input logic [1:0] c, input logic g, input logic f);
    return {s, 1'b0, c, g, f, 1'b1};
  endfunction

  // hold off a start until the capacitor tracks the input again; a go in the post wait would lag
  task automatic wait_acq();
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (sample_connect !== 1'b1 && n < 2000);
  endtask

  // power up, start, wait for the interrupt, then compare count, result and status
  task automatic convert(input logic [1:0] s, input logic [1:0] c, input int half);
    int n;
    n = 0;
    vin = $urandom % 256;
    res_q.push_back(vin);
    wr(8'h08, cb(s, c, 1'b0, 1'b0));
    wait_acq();
    wr(8'h08, cb(s, c, 1'b1, 1'b0));
    #1;
    // n ends as the count of edges from the conversion start to the flag
    while (irq !== 1'b1 && n < 2000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (half > 0) check(16'(n), 16'(19 * half));
    @(posedge sys_clk);
    rd(8'h09, 8'(res_q.pop_front()));
    rd(8'h08, cb(s, c, 1'b0, 1'b1));
  endtask

  ////////////////////////////////////////
  initial begin
    logic [7:0] d;
    logic [7:0] regs[7];
    logic [7:0] en[3];
    regs = '{8'h08, 8'h1f, 8'h88, 8'h9f, 8'h09, 8'h0b, 8'h33};
    en = '{8'h40, 8'h80, 8'hc0};
    void'($urandom(26474));
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    check(16'({vref_external, analog_pin_mask, converter_active, irq}), 16'h3c);
    foreach (regs[i]) rd(regs[i], 8'h00);
    // every clock code and channel through both aliases; bit 5 must read low
    for (int i = 0; i < 4; i++) begin
      d = {2'(i), 1'b1, 2'(3 - i), 1'b0, 1'($urandom), 1'b0};
      wr(i[0] ? 8'h1f : 8'h08, d);
      rd(8'h08, d & 8'hdf);
      check(16'(channel_sel), 16'(3 - i));
      wr(i[1] ? 8'h9f : 8'h88, {6'($urandom), 2'(i)});
      rd(8'h88, 8'(i));
      check(16'({vref_external, analog_pin_mask}), (i == 0) ? 16'h0f : (i == 1) ? 16'h17 : 16'h00);
    end
    wr(8'h33, 8'hff);
    rd(8'h33, 8'h00);
    wr(8'h08, 8'h04);
    rd(8'h08, 8'h00);
    check(16'(converter_active), 16'h0);
    wr(8'h0b, 8'hc0);
    // each oscillator clock, then the enable table on the last flag
    for (int s = 0; s < 3; s++) begin
      convert(2'(s), 2'($urandom), 1 << (2 * s));
      check(16'(irq), 16'h1);
      if (s == 2) foreach (en[k]) begin
        wr(8'h0b, en[k]);
        check(16'(irq), 16'(k == 2));
      end
      wr(8'h08, cb(2'(s), 2'h0, 1'b0, 1'b0));
      check(16'(irq), 16'h0);
    end
    // abort mid-run: old result kept, input reconnected after the wait
    old = vin;
    vin = 255 - old;
    wait_acq();
    wr(8'h08, cb(2'h1, 2'h2, 1'b1, 1'b0));
    repeat (20) @(posedge sys_clk);
    wr(8'h08, cb(2'h1, 2'h2, 1'b0, 1'b0));
    // sixteen cycles cut off from the abort edge: still off in the last, on right after
    repeat (15) @(posedge sys_clk);
    check(16'(sample_connect), 16'h0);
    @(posedge sys_clk);
    check(16'(sample_connect), 16'h1);
    rd(8'h09, 8'(old));
    rd(8'h08, cb(2'h1, 2'h2, 1'b0, 1'b0));
    // sleep on an oscillator clock kills the run
    wr(8'h08, cb(2'h2, 2'h1, 1'b1, 1'b0));
    repeat (30) @(posedge sys_clk);
    sleep_mode <= 1'b1;
    @(posedge sys_clk);
    rd(8'h08, cb(2'h2, 2'h1, 1'b0, 1'b0));
    check(16'(converter_active), 16'h0);
    rd(8'h09, 8'(old));
    // the rc clock keeps converting asleep and wakes the device
    w0 = wakes;
    convert(2'h3, 2'h3, 0);
    check(16'(converter_active), 16'h1);
    check(16'(wakes - w0), 16'h1);
    sleep_mode <= 1'b0;
    wr(8'h08, 8'h00);
    print_verdict();
  end
endmodule // sarcc_top_tb
`default_nettype wire
